// file: inc/ztrs_map.svh
`ifndef ZTRS_MAP_SVH
`define ZTRS_MAP_SVH

// ==================================================================
// register offsets (byte addresses, one word each)
`define ZTRS_OFS_CTRL     8'h00
`define ZTRS_OFS_DLY0     8'h04
`define ZTRS_OFS_DROPOUT  8'h1c
`define ZTRS_OFS_STATUS   8'h20

// ==================================================================
// control field positions
`define ZTRS_CTRL_EXT     0
`define ZTRS_CTRL_Z4REV   1
`define ZTRS_CTRL_INTREC  2
`define ZTRS_CTRL_PHEN    8
`define ZTRS_CTRL_GNEN    12

// ==================================================================
// status field positions
`define ZTRS_ST_TRIP      0
`define ZTRS_ST_RR        1
`define ZTRS_ST_FLAG      2
`define ZTRS_ST_STRETCH   3
`define ZTRS_ST_ARMED     4
`define ZTRS_ST_DONE      8

// ==================================================================
// reset values
`define ZTRS_CTRL_RST     16'hff00
`define ZTRS_DLY_RST      16'h0000

// ==================================================================
// timing: delays count in units of one millisecond tick
`define ZTRS_CLK_NS       10
`define ZTRS_TICK_NS      1000000
`define ZTRS_TICK_CYC     (`ZTRS_TICK_NS / `ZTRS_CLK_NS)

`endif

// file: inc/ztrs_pkg.sv
package ztrs_pkg;
   // ===============================================================
   // shared widths and types
   localparam int ZTRS_NTMR = 6;
   typedef logic [15:0] ztrs_dly_t;
   typedef logic [7:0]  ztrs_addr_t;
   typedef logic [31:0] ztrs_word_t;

   // internal reach-reset flag sequencing
   typedef enum logic [2:0] {
      RR_CLEAR = 3'b001,
      RR_SET   = 3'b010,
      RR_LOCK  = 3'b100
   } ztrs_rr_e;
endpackage

// file: inc/ztrs_tmr_if.sv
// ==================================================================
// one delay timer: level in, delay and tick in, level out
interface ztrs_tmr_if;
   logic                 start;
   ztrs_pkg::ztrs_dly_t  delay;
   logic                 tick;
   logic                 done;
   modport ctl (output start, output delay, output tick, input done);
   modport tmr (input start, input delay, input tick, output done);
endinterface

// file: src/ztrs_zone_timer.sv
// ==================================================================
// pickup delay: done once start has held for delay ticks
module ztrs_zone_timer
(
   input  wire logic  clock,
   input  wire logic  rst,
   ztrs_tmr_if.tmr    t
);
   import ztrs_pkg::*;

   typedef struct packed {
      ztrs_dly_t cnt;
      logic      done;
   } ztrs_zt_s;

   ztrs_zt_s st_r;
   ztrs_zt_s st_nxt;

   // count ticks while picked up; any dropout restarts the delay
   always_comb
   begin
      st_nxt = st_r;
      if (!t.start)
      begin
         st_nxt.cnt  = '0;
         st_nxt.done = 1'b0;
      end
      else if (st_r.cnt >= t.delay)
         st_nxt.done = 1'b1;
      else if (t.tick)
         st_nxt.cnt = st_r.cnt + 16'h0001;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign t.done = st_r.done;
endmodule

// file: src/ztrs_stretch.sv
// ==================================================================
// dropout stretch: output follows input, falls delay ticks late
module ztrs_stretch
(
   input  wire logic  clock,
   input  wire logic  rst,
   ztrs_tmr_if.tmr    t
);
   import ztrs_pkg::*;

   typedef struct packed {
      ztrs_dly_t cnt;
      logic      done;
   } ztrs_st_s;

   ztrs_st_s st_r;
   ztrs_st_s st_nxt;

   // delay of zero gives a plain one-cycle copy of the input
   always_comb
   begin
      st_nxt = st_r;
      if (t.start)
      begin
         st_nxt.cnt  = '0;
         st_nxt.done = 1'b1;
      end
      else if (st_r.done)
      begin
         if (st_r.cnt >= t.delay)
            st_nxt.done = 1'b0;
         else if (t.tick)
            st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign t.done = st_r.done;
endmodule

// file: src/ztrs_top.sv
`include "ztrs_map.svh"

module ztrs_top
#(
   parameter int TICK_CYCLES = `ZTRS_TICK_CYC
)
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire ztrs_pkg::ztrs_addr_t addr,
   input  wire ztrs_pkg::ztrs_word_t wr_data,
   input  wire logic                 wr_en,
   input  wire logic                 rd_en,
   output      ztrs_pkg::ztrs_word_t rd_data,
   input  wire logic [3:0]           zone_phase_pickup,
   input  wire logic [3:0]           zone_gnd_pickup,
   input  wire logic                 zone4_rev_phase_pickup,
   input  wire logic                 zone4_rev_gnd_pickup,
   input  wire logic                 fault_detector,
   input  wire logic                 recloser_contact_input,
   input  wire logic                 recloser_initiate,
   input  wire logic                 recloser_in_reset,
   input  wire logic                 reclose_locked_state,
   input  wire logic                 breaker_manual_close,
   output      logic                 trip_request,
   output      logic                 reach_reset_output
);
   import ztrs_pkg::*;

   // ===============================================================
   // pin inputs gathered into one vector for synchronising
   // every pin is taken as asynchronous to clock: contacts and
   // measuring flags may move at any moment, so none is read raw
   localparam int NPIN = 16;

   typedef struct packed {
      logic [NPIN-1:0] sync1;
      logic [NPIN-1:0] sync2;
      logic [16:0]     tick_cnt;
      logic            tick;
      logic [15:0]     ctrl;
      ztrs_dly_t [ZTRS_NTMR-1:0] dly;
      ztrs_dly_t       dropout;
      ztrs_rr_e        rr;
      logic            close_seen;
      logic            reset_prev;
      logic            armed;
      logic            trip;
      logic            rr_out;
      ztrs_word_t      rd_data;
   } ztrs_top_s;

   ztrs_top_s st_r;
   ztrs_top_s st_nxt;

   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] pin_s;
   logic [3:0]  ph_pu;
   logic [3:0]  gn_pu;
   logic        ph4_sel;
   logic        gn4_sel;
   logic        fd_s;
   logic        contact_s;
   logic        init_s;
   logic        in_reset_s;
   logic        lock_s;
   logic        close_s;
   logic [3:0]  ph_on;
   logic [3:0]  gn_on;
   logic [ZTRS_NTMR-1:0] tmr_start;
   logic [ZTRS_NTMR-1:0] tmr_done;
   logic        stretched;
   logic        flag_set;
   logic        reach_reset;
   logic        ext_mode;
   logic        z4_rev;
   logic        int_rec;
   logic        instant;
   logic        timed;
   logic        unsup_trip;
   logic        reset_rise;
   ztrs_word_t  status;

   // ===============================================================
   // input synchronisers: only sync2 is read by logic
   // the order of this concatenation fixes the indices used below
   assign pins = {breaker_manual_close, reclose_locked_state,
                  recloser_in_reset, recloser_initiate,
                  recloser_contact_input, fault_detector,
                  zone4_rev_gnd_pickup, zone4_rev_phase_pickup,
                  zone_gnd_pickup, zone_phase_pickup};
   assign pin_s = st_r.sync2;

   // unpacked views of the synchronised pins
   assign ph_pu      = pin_s[3:0];
   assign gn_pu      = pin_s[7:4];
   // zone 4 direction picks which pickup pair counts as zone 4
   assign ph4_sel    = z4_rev ? pin_s[8] : ph_pu[3];
   assign gn4_sel    = z4_rev ? pin_s[9] : gn_pu[3];
   assign fd_s       = pin_s[10];
   assign contact_s  = pin_s[11];
   assign init_s     = pin_s[12];
   assign in_reset_s = pin_s[13];
   assign lock_s     = pin_s[14];
   assign close_s    = pin_s[15];

   // ===============================================================
   // configuration decode
   // mode bits act from the cycle after the write
   assign ext_mode = st_r.ctrl[`ZTRS_CTRL_EXT];
   assign z4_rev   = st_r.ctrl[`ZTRS_CTRL_Z4REV];
   assign int_rec  = st_r.ctrl[`ZTRS_CTRL_INTREC];

   // per-zone enables; zone 4 takes its chosen direction
   // a disabled zone neither trips at once nor starts its timers
   assign ph_on = st_r.ctrl[`ZTRS_CTRL_PHEN +: 4] &
                  {ph4_sel, ph_pu[2:0]};
   assign gn_on = st_r.ctrl[`ZTRS_CTRL_GNEN +: 4] &
                  {gn4_sel, gn_pu[2:0]};

   // ===============================================================
   // zone timers: even index phase, odd index ground, zones 2..4
   // index 2k serves zone k+2 phase, 2k+1 zone k+2 ground; a pickup
   // that drops for one cycle restarts its timer, trading a slower
   // trip on a chattering pickup for no trip on a passing one
   ztrs_tmr_if tif [ZTRS_NTMR] ();

   genvar gi;
   generate
      for (gi = 0; gi < ZTRS_NTMR; gi++)
      begin : g_tmr
         // phase and ground timers start from their own pickups
         assign tmr_start[gi] = (gi % 2 == 0) ?
                                ph_on[gi/2 + 1] : gn_on[gi/2 + 1];
         assign tif[gi].start = tmr_start[gi];
         assign tif[gi].delay = st_r.dly[gi];
         assign tif[gi].tick  = st_r.tick;
         assign tmr_done[gi]  = tif[gi].done;
         ztrs_zone_timer u_tmr
         (
            .clock (clock),
            .rst   (rst),
            .t     (tif[gi].tmr)
         );
      end
   endgenerate

   // ===============================================================
   // external recloser contact stretch
   // without it a contact that only pulses at each reclose step
   // would hand zone 2 its instant reach back between the steps
   ztrs_tmr_if sif ();

   assign sif.start = contact_s;
   assign sif.delay = st_r.dropout;
   assign sif.tick  = st_r.tick;
   assign stretched = sif.done;

   ztrs_stretch u_stretch
   (
      .clock (clock),
      .rst   (rst),
      .t     (sif.tmr)
   );

   // ===============================================================
   // trip decision
   // lock and set both count as a raised flag
   assign flag_set    = (st_r.rr != RR_CLEAR);
   // internal flag replaces the contact when the option is present
   assign reach_reset = int_rec ? flag_set : stretched;

   // zone 1 always instant; zone 2 joins only before a reclose
   // zone 2 is the overreach here, so it may sit in the instant
   // path only while no reclose cycle is running
   assign instant = ph_on[0] | gn_on[0] |
                    (ext_mode & ~reach_reset &
                     (ph_on[1] | gn_on[1]));

   // stepped zones stay live under every mode, incl. reclaim
   assign timed      = |tmr_done;
   assign unsup_trip = instant | timed;
   assign reset_rise = in_reset_s & ~st_r.reset_prev;

   // status word for software
   // trip and reach bits are the registered pins, so software sees
   // exactly what the outputs show
   always_comb
   begin
      status = '0;
      status[`ZTRS_ST_TRIP]    = st_r.trip;
      status[`ZTRS_ST_RR]      = st_r.rr_out;
      status[`ZTRS_ST_FLAG]    = flag_set;
      status[`ZTRS_ST_STRETCH] = stretched;
      status[`ZTRS_ST_ARMED]   = st_r.armed;
      status[`ZTRS_ST_DONE +: ZTRS_NTMR] = tmr_done;
   end

   // ===============================================================
   // next state: sync, tick divider, flag sequence, bus, outputs
   always_comb
   begin
      st_nxt = st_r;

      // two-stage synchroniser on every pin
      st_nxt.sync1 = pins;
      st_nxt.sync2 = st_r.sync1;

      // millisecond tick enable for all delay timers
      // one divider keeps every timer on a common base; the first
      // tick after a pickup may come up to one period late
      st_nxt.tick = 1'b0;
      if (st_r.tick_cnt >= 17'(TICK_CYCLES - 1))
      begin
         st_nxt.tick_cnt = '0;
         st_nxt.tick     = 1'b1;
      end
      else
         st_nxt.tick_cnt = st_r.tick_cnt + 17'h00001;

      // reach-reset flag: set on initiate, clear on reset entry or, once locked, on reset after a manual close
      st_nxt.reset_prev = in_reset_s;
      case (st_r.rr)
         RR_CLEAR:
         begin
            // initiate alone sets the flag, whatever the breaker does
            if (init_s)
               st_nxt.rr = RR_SET;
         end
         RR_SET:
         begin
            // a new initiate beats a reset in the same cycle
            if (lock_s)
            begin
               st_nxt.rr         = RR_LOCK;
               st_nxt.close_seen = 1'b0;
            end
            else if (reset_rise && !init_s)
               st_nxt.rr = RR_CLEAR;
         end
         RR_LOCK:
         begin
            // reclose_locked_state needs a manual close before reset counts
            if (close_s)
               st_nxt.close_seen = 1'b1;
            if ((st_r.close_seen || close_s) && in_reset_s &&
                !lock_s && !init_s)
               st_nxt.rr = RR_CLEAR;
         end
         // an illegal code falls back to clear
         default:
            st_nxt.rr = RR_CLEAR;
      endcase

      // register writes
      // unmapped addresses fall through and change nothing
      if (wr_en)
      begin
         if (addr == `ZTRS_OFS_CTRL)
            st_nxt.ctrl = wr_data[15:0];
         else if (addr == `ZTRS_OFS_DROPOUT)
            st_nxt.dropout = wr_data[15:0];
         else
         begin
            for (int i = 0; i < ZTRS_NTMR; i++)
            begin
               if (addr == 8'(`ZTRS_OFS_DLY0 + 4 * i))
                  st_nxt.dly[i] = wr_data[15:0];
            end
         end
      end

      // register reads: data stands for one cycle only
      st_nxt.rd_data = '0;
      if (rd_en)
      begin
         if (addr == `ZTRS_OFS_CTRL)
            st_nxt.rd_data = {16'h0000, st_r.ctrl};
         else if (addr == `ZTRS_OFS_DROPOUT)
            st_nxt.rd_data = {16'h0000, st_r.dropout};
         else if (addr == `ZTRS_OFS_STATUS)
            st_nxt.rd_data = status;
         else
         begin
            for (int i = 0; i < ZTRS_NTMR; i++)
            begin
               if (addr == 8'(`ZTRS_OFS_DLY0 + 4 * i))
                  st_nxt.rd_data = {16'h0000, st_r.dly[i]};
            end
         end
      end

      // arm one cycle after reset so the mode is settled first
      // the first edge after reset only loads registers, never trips
      st_nxt.armed = 1'b1;

      // outputs: trip only with a detected fault
      // no scheme bypasses this gate, the instant path included
      st_nxt.trip   = st_r.armed & fd_s & unsup_trip;
      st_nxt.rr_out = flag_set;
   end

   // ===============================================================
   // state register; timers and flag clear under reset
   // ctrl and rr take non-zero reset codes; the rest starts at zero
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_r         <= '0;
         st_r.ctrl    <= `ZTRS_CTRL_RST;
         st_r.rr      <= RR_CLEAR;
         st_r.dropout <= `ZTRS_DLY_RST;
      end
      else
         st_r <= st_nxt;
   end

   // ===============================================================
   // top outputs straight from the state register
   // rd_data is zero except in the one cycle after a read strobe,
   // so a bus that ORs several slaves needs no extra gating
   assign rd_data            = st_r.rd_data;
   assign trip_request       = st_r.trip;
   assign reach_reset_output = st_r.rr_out;
endmodule

// file: tb/ztrs_recl_model.sv
// ==================================================================
// recloser and breaker as seen from the relay
module ztrs_recl_model
#(
   parameter int RECLAIM = 100
)
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic trip_request,
   input  wire logic hold_mode,
   input  wire logic lock_cmd,
   output logic      recloser_contact_input,
   output logic      recloser_initiate,
   output logic      recloser_in_reset,
   output logic      reclose_locked_state
);
   logic [7:0] trip_d;
   logic [7:0] cnt;

   // breaker opens 8 cycles after a trip, then one reclose cycle runs
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         trip_d <= '0;
         cnt <= '0;
         recloser_contact_input <= 1'b0;
         recloser_initiate <= 1'b0;
         recloser_in_reset <= 1'b1;
         reclose_locked_state <= 1'b0;
      end
      else
      begin
         trip_d <= {trip_d[6:0], trip_request};
         if (recloser_in_reset && trip_d[7])
         begin
            cnt <= 8'(RECLAIM);
            recloser_initiate <= 1'b1;
            recloser_in_reset <= 1'b0;
            recloser_contact_input <= 1'b1;
         end
         else if (!recloser_in_reset)
         begin
            // pulse mode drops the contact after one cycle
            recloser_contact_input <= hold_mode;
            reclose_locked_state <= lock_cmd;
            // lock_cmd freezes the reclaim count
            if (cnt == 8'h00)
            begin
               recloser_in_reset <= 1'b1;
               recloser_initiate <= 1'b0;
               recloser_contact_input <= 1'b0;
            end
            else if (!lock_cmd)
               cnt <= cnt - 8'h01;
         end
      end
endmodule

// file: tb/ztrs_top_chk.sv
// ==================================================================
// port checker for the trip and reach-reset selector
module ztrs_top_chk
(
   input wire logic                 clock,
   input wire logic                 rst,
   input wire ztrs_pkg::ztrs_addr_t addr,
   input wire ztrs_pkg::ztrs_word_t wr_data,
   input wire logic                 wr_en,
   input wire logic                 rd_en,
   input wire ztrs_pkg::ztrs_word_t rd_data,
   input wire logic [3:0]           zone_phase_pickup,
   input wire logic                 fault_detector,
   input wire logic                 recloser_contact_input,
   input wire logic                 recloser_initiate,
   input wire logic                 recloser_in_reset,
   input wire logic                 trip_request,
   input wire logic                 reach_reset_output
);
   import ztrs_pkg::*;
   logic [15:0] ctrl_r;

   // shadow of the control word so modes are known here
   always_ff @(posedge clock or posedge rst)
      if (rst)
         ctrl_r <= 16'hff00;
      else if (wr_en && addr == 8'h00)
         ctrl_r <= wr_data[15:0];

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // ===============================================================
   // trip path
   a_no_fd_trip: assert property (!fault_detector [*4] |=> !trip_request)
      else $error("trip without fault detector");
   a_zone1_trip: assert property
      ((zone_phase_pickup[0] && fault_detector && ctrl_r[8]) [*4]
       |=> trip_request)
      else $error("zone 1 pickup did not trip");

   // ===============================================================
   // register port
   a_rd_idle: assert property (!rd_en |=> rd_data == '0)
      else $error("read data not zero outside read");
   a_rd_upper: assert property (rd_en |=> rd_data[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_unmapped_rd: assert property (rd_en && addr > 8'h20 |=> rd_data == '0)
      else $error("unmapped read not zero");
   a_ctrl_read: assert property
      (rd_en && addr == 8'h00
       |=> (rd_data[15:0] & 16'hff07) == (ctrl_r & 16'hff07))
      else $error("control readback wrong");
   a_status_out: assert property
      (rd_en && addr == 8'h20
       |=> rd_data[1:0] == $past({reach_reset_output, trip_request}))
      else $error("status does not match outputs");

   // ===============================================================
   // reach reset
   a_ext_reach: assert property
      ((ctrl_r[0] && !ctrl_r[2] && recloser_contact_input) [*5]
       |=> reach_reset_output)
      else $error("contact did not raise reach reset");
   a_int_set: assert property
      ((ctrl_r[2] && recloser_initiate) [*5] |=> reach_reset_output)
      else $error("initiate did not set flag");
   a_int_hold: assert property
      ((ctrl_r[2] && reach_reset_output && !recloser_in_reset) [*6]
       |=> reach_reset_output)
      else $error("flag cleared outside reset state");
endmodule

bind ztrs_top ztrs_top_chk u_chk
(
   .clock,
   .rst,
   .addr,
   .wr_data,
   .wr_en,
   .rd_en,
   .rd_data,
   .zone_phase_pickup,
   .fault_detector,
   .recloser_contact_input,
   .recloser_initiate,
   .recloser_in_reset,
   .trip_request,
   .reach_reset_output
);

// file: tb/test_zone_trip_reach_selector.sv
`define CMP(e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL rd_data exp %h got %h", e, g); end end

module test_zone_trip_reach_selector;
   timeunit 1ns;
   timeprecision 1ps;
   import ztrs_pkg::*;
   typedef struct {ztrs_word_t e; ztrs_word_t m;} ztrs_exp_s;
   logic       clock = 0, rst = 1, wr_en = 0, rd_en = 0;
   ztrs_addr_t addr = '0;
   ztrs_word_t wr_data = '0, rd_data, v;
   logic [3:0] zone_phase_pickup = '0, zone_gnd_pickup = '0;
   logic       zone4_rev_phase_pickup = 0, zone4_rev_gnd_pickup = 0;
   logic       fault_detector = 0, breaker_manual_close = 0;
   logic       hold_mode = 1, lock_cmd = 0, rd_seen = 0;
   logic       recloser_contact_input, recloser_initiate;
   logic       recloser_in_reset, reclose_locked_state;
   logic       trip_request, reach_reset_output;
   int         bad_count = 0, tests_run = 0, cyc = 0;
   int         seed = 32'hd4ccbe7a;
   ztrs_exp_s  ex;
   ztrs_exp_s  exp_q[$];

   ztrs_top #(.TICK_CYCLES(10)) u_dut (.clock, .rst, .addr, .wr_data,
      .wr_en, .rd_en, .rd_data, .zone_phase_pickup, .zone_gnd_pickup,
      .zone4_rev_phase_pickup, .zone4_rev_gnd_pickup, .fault_detector,
      .recloser_contact_input, .recloser_initiate, .recloser_in_reset,
      .reclose_locked_state, .breaker_manual_close, .trip_request,
      .reach_reset_output);
   ztrs_recl_model u_recl (.clock, .rst, .trip_request, .hold_mode,
      .lock_cmd, .recloser_contact_input, .recloser_initiate,
      .recloser_in_reset, .reclose_locked_state);

   // 100 MHz clock
   always #5 clock = ~clock;

   // ===============================================================
   // bus tasks, one idle cycle after each strobe
   task automatic wr(input ztrs_addr_t a, input logic [15:0] d);
      addr <= a;
      wr_data <= {16'h0000, d};
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask

   task automatic chk(input ztrs_addr_t a, input ztrs_word_t m,
                      input ztrs_word_t e);
      exp_q.push_back('{e & m, m});
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(posedge clock);
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge clock)
   begin
      if (rd_seen)
      begin
         ex = exp_q.pop_front();
         `CMP(ex.e, rd_data & ex.m)
      end
      rd_seen = rd_en;
   end

   // hang guard, well above the expected run length
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   // ===============================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(8'h00, 32'hffffffff, 32'h0000ff00);
      chk(8'h20, 32'h3, 0);
      chk(8'h44, 32'hffffffff, 0);
      for (int i = 1; i < 8; i++)
      begin
         chk(8'(4 * i), 32'hffffffff, 0);
         v = $random(seed);
         wr(8'(4 * i), v[15:0]);
         chk(8'(4 * i), 32'hffffffff, v & 32'hffff);
      end
      $display("test registers done");
      zone_phase_pickup <= 4'h1;
      w(6);
      chk(8'h20, 32'h1, 0);
      fault_detector <= 1'b1;
      w(5);
      chk(8'h20, 32'h1, 1);
      wr(8'h00, 16'hfe00);
      w(5);
      chk(8'h20, 32'h1, 0);
      zone_phase_pickup <= 4'h0;
      zone_gnd_pickup <= 4'h1;
      w(5);
      chk(8'h20, 32'h1, 1);
      wr(8'h00, 16'hef00);
      w(5);
      chk(8'h20, 32'h1, 0);
      zone_gnd_pickup <= 4'h0;
      wr(8'h00, 16'hff00);
      $display("test instant zone done");
      // phase delays 2 ticks, ground 6 ticks, zones 2 to 4
      for (int k = 0; k < 6; k++)
      begin
         wr(8'(4 + 4 * k), k[0] ? 16'h0006 : 16'h0002);
         if (k[0])
            zone_gnd_pickup <= 4'(2 << (k / 2));
         else
            zone_phase_pickup <= 4'(2 << (k / 2));
         w(k[0] ? 40 : 8);
         chk(8'h20, 32'h1, 0);
         w(30);
         chk(8'h20, 32'h1, 1);
         zone_phase_pickup <= 4'h0;
         zone_gnd_pickup <= 4'h0;
         w(6);
      end
      wr(8'h00, 16'hff02);
      zone_phase_pickup <= 4'h8;
      w(40);
      chk(8'h20, 32'h1, 0);
      zone4_rev_phase_pickup <= 1'b1;
      zone4_rev_gnd_pickup <= 1'b1;
      w(40);
      chk(8'h20, 32'h1, 1);
      zone_phase_pickup <= 4'h0;
      zone4_rev_phase_pickup <= 1'b0;
      zone4_rev_gnd_pickup <= 1'b0;
      $display("test timed zones done");
      w(150);
      wr(8'h04, 16'h0006);
      wr(8'h1c, 16'h0000);
      wr(8'h00, 16'hff01);
      zone_phase_pickup <= 4'h2;
      w(4);
      chk(8'h20, 32'h1, 1);
      w(20);
      chk(8'h20, 32'hb, 32'ha);
      w(60);
      chk(8'h20, 32'hb, 32'hb);
      zone_phase_pickup <= 4'h0;
      w(40);
      chk(8'h20, 32'hb, 0);
      hold_mode <= 1'b0;
      wr(8'h1c, 16'h0005);
      zone_phase_pickup <= 4'h2;
      w(4);
      zone_phase_pickup <= 4'h0;
      w(25);
      chk(8'h20, 32'ha, 32'ha);
      w(60);
      chk(8'h20, 32'ha, 32'h2);
      $display("test extension mode done");
      w(40);
      hold_mode <= 1'b1;
      lock_cmd <= 1'b1;
      wr(8'h00, 16'hff05);
      zone_phase_pickup <= 4'h2;
      w(4);
      zone_phase_pickup <= 4'h0;
      w(25);
      chk(8'h20, 32'h6, 32'h6);
      lock_cmd <= 1'b0;
      w(120);
      chk(8'h20, 32'h6, 32'h6);
      breaker_manual_close <= 1'b1;
      w(3);
      breaker_manual_close <= 1'b0;
      w(10);
      chk(8'h20, 32'h6, 0);
      $display("test internal recloser done");
      wrap_up();
   end
endmodule
